// ==== pls_regs.svh ====
`ifndef PLS_REGS_SVH
`define PLS_REGS_SVH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define PLS_CMD_OT_ACTION   8'h50
`define PLS_CMD_WARN_THR    8'h51
`define PLS_CMD_VIN_OV_THR  8'h55
`define PLS_CMD_TURN_ON_DLY 8'h60
`define PLS_CMD_RISE_TIME   8'h61

// ----------------------------------------------------------------
// fixed read-only upper parts (exponent plus zero bits)
// ----------------------------------------------------------------
`define PLS_OT_ACTION_TOP   2'h2
`define PLS_WARN_FIXED      10'h040
`define PLS_VIN_OV_FIXED    12'h080
`define PLS_TURN_ON_FIXED   13'h1F00
`define PLS_RISE_FIXED      10'h3E0

// ----------------------------------------------------------------
// restore values
// ----------------------------------------------------------------
`define PLS_RETRY_RST       1'h0
`define PLS_WARN_RST        6'h22
`define PLS_VIN_OV_RST      4'h9
`define PLS_TURN_ON_RST     3'h0
`define PLS_RISE_RST        6'h00

// ----------------------------------------------------------------
// threshold bins
// ----------------------------------------------------------------
`define PLS_WARN_BIN_115    6'h1D
`define PLS_WARN_BIN_120    6'h1E
`define PLS_WARN_BIN_125    6'h1F
`define PLS_WARN_BIN_130    6'h20
`define PLS_TEMP_110        8'h6E
`define PLS_TEMP_115        8'h73
`define PLS_TEMP_120        8'h78
`define PLS_TEMP_125        8'h7D
`define PLS_TEMP_130        8'h82
`define PLS_VIN_BIN_HIGH    4'h9
`define PLS_VIN_MV_HIGH     16'h4844
`define PLS_VIN_MV_LOW      16'h4074

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PLS_CLK_MHZ         40
`define PLS_MIN_DLY_US      50
`define PLS_MIN_DLY_CYC     (`PLS_MIN_DLY_US * `PLS_CLK_MHZ)
`define PLS_STEP_US         500
`define PLS_STEP_CYC        (`PLS_STEP_US * `PLS_CLK_MHZ)
`define PLS_HICCUP_MS       52
`define PLS_HICCUP_CYC      (`PLS_HICCUP_MS * 1000 * `PLS_CLK_MHZ)

`endif

// ==== pls_pkg.sv ====
package pls_pkg;
    typedef enum logic [2:0] {
        PLS_OFF    = 3'b000,
        PLS_DELAY  = 3'b001,
        PLS_RISE   = 3'b010,
        PLS_ON     = 3'b011,
        PLS_HICCUP = 3'b100,
        PLS_LATCH  = 3'b101
    } pls_state_t;
endpackage : pls_pkg

// ==== pls_protect_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pls_regs.svh"

module pls_protect_regs
    import pls_pkg::*;
#(
    parameter int TW          = 22,
    parameter int STEP_CYC    = `PLS_STEP_CYC,
    parameter int HICCUP_CYC  = `PLS_HICCUP_CYC
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    input  wire logic        i_cmd_valid,
    input  wire logic        i_cmd_write,
    input  wire logic [7:0]  i_cmd_code,
    input  wire logic [15:0] i_cmd_wdata,
    input  wire logic        i_clear_faults,
    input  wire logic        i_enable,
    input  wire logic        i_ot_fault,
    input  wire logic [7:0]  i_die_temp_c,
    input  wire logic [15:0] i_power_input_voltage_mv,
    output logic             o_cmd_done,
    output logic             o_cmd_nack,
    output logic [15:0]      o_cmd_rdata,
    output logic             o_conv_en,
    output logic             o_dac_ramp,
    output logic [2:0]       o_rise_sel,
    output logic             o_temp_warning_flag,
    output logic             o_temp_fault_flag,
    output logic             o_input_overvoltage_flag,
    output logic             o_cml_flag,
    output logic             o_ivd_flag,
    output logic             o_smbalert_n
);

    // ------------------------------------------------------------
    // configuration storage
    // ------------------------------------------------------------
    logic          retry_q;
    logic [5:0]    warn_mant_q;
    logic [3:0]    vin_mant_q;
    logic [2:0]    dly_mant_q;
    logic [5:0]    rise_mant_q;
    logic          wr_ok;
    logic          wr_bad;
    logic          wr_unknown;
    logic [15:0]   rd_val;
    logic [2:0]    retry_field;

    assign retry_field = {3{retry_q}};

    always_comb begin
        wr_ok      = 1'b0;
        wr_unknown = 1'b0;
        rd_val     = 16'h0000;
        unique case (i_cmd_code)
            `PLS_CMD_OT_ACTION: begin
                // retry and mirror must agree, all zeros or all ones
                wr_ok  = (i_cmd_wdata[15:6] == {8'h00, `PLS_OT_ACTION_TOP}) &&
                         (i_cmd_wdata[5:0] == 6'h00 || i_cmd_wdata[5:0] == 6'h3F);
                rd_val = {8'h00, `PLS_OT_ACTION_TOP, retry_field, retry_field};
            end
            `PLS_CMD_WARN_THR: begin
                wr_ok  = (i_cmd_wdata[15:6] == `PLS_WARN_FIXED);
                rd_val = {`PLS_WARN_FIXED, warn_mant_q};
            end
            `PLS_CMD_VIN_OV_THR: begin
                wr_ok  = (i_cmd_wdata[15:4] == `PLS_VIN_OV_FIXED);
                rd_val = {`PLS_VIN_OV_FIXED, vin_mant_q};
            end
            `PLS_CMD_TURN_ON_DLY: begin
                wr_ok  = (i_cmd_wdata[15:3] == `PLS_TURN_ON_FIXED);
                rd_val = {`PLS_TURN_ON_FIXED, dly_mant_q};
            end
            `PLS_CMD_RISE_TIME: begin
                wr_ok  = (i_cmd_wdata[15:6] == `PLS_RISE_FIXED);
                rd_val = {`PLS_RISE_FIXED, rise_mant_q};
            end
            default: begin
                wr_unknown = 1'b1;
            end
        endcase
    end

    assign wr_bad = i_cmd_valid && i_cmd_write && !wr_ok;

    // mantissas store exactly what was written; bins act on them
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            retry_q     <= `PLS_RETRY_RST;
            warn_mant_q <= `PLS_WARN_RST;
            vin_mant_q  <= `PLS_VIN_OV_RST;
            dly_mant_q  <= `PLS_TURN_ON_RST;
            rise_mant_q <= `PLS_RISE_RST;
        end else if (i_cmd_valid && i_cmd_write && wr_ok) begin
            unique case (i_cmd_code)
                `PLS_CMD_OT_ACTION:   retry_q     <= i_cmd_wdata[5];
                `PLS_CMD_WARN_THR:    warn_mant_q <= i_cmd_wdata[5:0];
                `PLS_CMD_VIN_OV_THR:  vin_mant_q  <= i_cmd_wdata[3:0];
                `PLS_CMD_TURN_ON_DLY: dly_mant_q  <= i_cmd_wdata[2:0];
                `PLS_CMD_RISE_TIME:   rise_mant_q <= i_cmd_wdata[5:0];
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // command answer, one cycle after the request
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_cmd_done  <= 1'b0;
            o_cmd_nack  <= 1'b0;
            o_cmd_rdata <= 16'h0000;
        end else begin
            o_cmd_done  <= i_cmd_valid;
            o_cmd_nack  <= i_cmd_valid && (wr_unknown || wr_bad);
            if (i_cmd_valid && !i_cmd_write) begin
                o_cmd_rdata <= rd_val;
            end
        end
    end

    // ------------------------------------------------------------
    // threshold bins and comparators
    // ------------------------------------------------------------
    logic [7:0]  warn_c;
    logic [15:0] vin_thr_mv;
    logic        warn_hit;
    logic        vin_ov;

    always_comb begin
        // codes below the lowest bin use 110, codes above the highest use 130
        if (warn_mant_q >= `PLS_WARN_BIN_130) begin
            warn_c = `PLS_TEMP_130;
        end else if (warn_mant_q == `PLS_WARN_BIN_125) begin
            warn_c = `PLS_TEMP_125;
        end else if (warn_mant_q == `PLS_WARN_BIN_120) begin
            warn_c = `PLS_TEMP_120;
        end else if (warn_mant_q == `PLS_WARN_BIN_115) begin
            warn_c = `PLS_TEMP_115;
        end else begin
            warn_c = `PLS_TEMP_110;
        end
    end

    assign vin_thr_mv = (vin_mant_q >= `PLS_VIN_BIN_HIGH) ? `PLS_VIN_MV_HIGH
                                                          : `PLS_VIN_MV_LOW;
    assign warn_hit   = (i_die_temp_c >= warn_c);
    assign vin_ov     = (i_power_input_voltage_mv > vin_thr_mv);

    // ------------------------------------------------------------
    // sequencer timing
    // ------------------------------------------------------------
    logic [TW-1:0] dly_cyc;
    logic [TW-1:0] rise_cyc;
    logic [2:0]    rise_sel;

    always_comb begin
        unique case (dly_mant_q)
            3'h0:    dly_cyc = TW'(`PLS_MIN_DLY_CYC);
            3'h1:    dly_cyc = TW'(STEP_CYC);
            3'h2:    dly_cyc = TW'(2 * STEP_CYC);
            default: dly_cyc = TW'(4 * STEP_CYC);
        endcase
        if (rise_mant_q >= 6'h20) begin
            rise_sel = 3'h5;
        end else if (rise_mant_q >= 6'h10) begin
            rise_sel = 3'h4;
        end else if (rise_mant_q >= 6'h08) begin
            rise_sel = 3'h3;
        end else if (rise_mant_q >= 6'h04) begin
            rise_sel = 3'h2;
        end else if (rise_mant_q >= 6'h02) begin
            rise_sel = 3'h1;
        end else begin
            rise_sel = 3'h0;
        end
        rise_cyc = TW'(STEP_CYC) << rise_sel;
    end

    // ------------------------------------------------------------
    // power sequencer
    // ------------------------------------------------------------
    pls_state_t    state_q;
    pls_state_t    state_d;
    logic [TW-1:0] tmr_q;
    logic          tmr_load;
    logic [TW-1:0] tmr_val;
    logic          running;

    assign running = (state_q == PLS_DELAY) || (state_q == PLS_RISE) ||
                     (state_q == PLS_ON) || (state_q == PLS_HICCUP);

    always_comb begin
        state_d  = state_q;
        tmr_load = 1'b0;
        tmr_val  = '0;
        unique case (state_q)
            PLS_OFF: begin
                if (i_enable && !i_ot_fault && !vin_ov) begin
                    state_d  = PLS_DELAY;
                    tmr_load = 1'b1;
                    tmr_val  = dly_cyc;
                end
            end
            PLS_DELAY: begin
                if (tmr_q == '0) begin
                    state_d  = PLS_RISE;
                    tmr_load = 1'b1;
                    tmr_val  = rise_cyc;
                end
            end
            PLS_RISE: begin
                if (tmr_q == '0) begin
                    state_d = PLS_ON;
                end
            end
            PLS_ON: begin
            end
            PLS_HICCUP: begin
                if (tmr_q == '0) begin
                    // restart only once the fault has gone
                    state_d  = i_ot_fault ? PLS_HICCUP : PLS_DELAY;
                    tmr_load = 1'b1;
                    tmr_val  = i_ot_fault ? TW'(HICCUP_CYC) : dly_cyc;
                end
            end
            PLS_LATCH: begin
                if (!i_enable && !i_ot_fault && !vin_ov) begin
                    state_d = PLS_OFF;
                end
            end
            default: begin
                state_d = PLS_OFF;
            end
        endcase
        if (running && vin_ov) begin
            state_d  = PLS_LATCH;
            tmr_load = 1'b0;
        end else if (running && !i_enable) begin
            state_d  = PLS_OFF;
            tmr_load = 1'b0;
        end else if (i_ot_fault && (state_q == PLS_DELAY || state_q == PLS_RISE ||
                                    state_q == PLS_ON)) begin
            state_d  = retry_q ? PLS_HICCUP : PLS_LATCH;
            tmr_load = retry_q;
            tmr_val  = TW'(HICCUP_CYC);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state_q <= PLS_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            tmr_q <= '0;
        end else if (tmr_load) begin
            tmr_q <= tmr_val;
        end else if (tmr_q != '0) begin
            tmr_q <= tmr_q - TW'(1);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_conv_en  <= 1'b0;
            o_dac_ramp <= 1'b0;
            o_rise_sel <= 3'h0;
        end else begin
            o_conv_en  <= (state_d == PLS_RISE) || (state_d == PLS_ON);
            o_dac_ramp <= (state_d == PLS_RISE);
            o_rise_sel <= rise_sel;
        end
    end

    // ------------------------------------------------------------
    // status flags and alert; a new event beats a clear
    // ------------------------------------------------------------
    logic warn_d;
    logic fault_d;
    logic vin_d;
    logic cml_d;
    logic ivd_d;

    always_comb begin
        warn_d  = warn_hit || (o_temp_warning_flag && !i_clear_faults);
        fault_d = i_ot_fault || (o_temp_fault_flag && !i_clear_faults);
        vin_d   = vin_ov || (o_input_overvoltage_flag && !i_clear_faults);
        cml_d   = (i_cmd_valid && (wr_unknown || wr_bad)) ||
                  (o_cml_flag && !i_clear_faults);
        ivd_d   = wr_bad || (o_ivd_flag && !i_clear_faults);
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_temp_warning_flag      <= 1'b0;
            o_temp_fault_flag        <= 1'b0;
            o_input_overvoltage_flag <= 1'b0;
            o_cml_flag               <= 1'b0;
            o_ivd_flag               <= 1'b0;
            o_smbalert_n             <= 1'b1;
        end else begin
            o_temp_warning_flag      <= warn_d;
            o_temp_fault_flag        <= fault_d;
            o_input_overvoltage_flag <= vin_d;
            o_cml_flag               <= cml_d;
            o_ivd_flag               <= ivd_d;
            o_smbalert_n             <= !(warn_d || fault_d || vin_d || cml_d);
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    property p_action_top;
        i_cmd_valid && !i_cmd_write && i_cmd_code == `PLS_CMD_OT_ACTION
            |=> o_cmd_rdata[7:6] == 2'b10 && o_cmd_rdata[5:0] == {6{$past(retry_q)}};
    endproperty
    a_action_top: assert property (p_action_top) else $error("action readback wrong");

    property p_bad_retry;
        i_cmd_valid && i_cmd_write && i_cmd_code == `PLS_CMD_OT_ACTION &&
            i_cmd_wdata[5:3] == 3'b010 |=> o_cmd_nack && retry_q == $past(retry_q);
    endproperty
    a_bad_retry: assert property (p_bad_retry) else $error("bad retry accepted");

    property p_latch_off;
        i_ot_fault && !vin_ov && i_enable && !retry_q && state_q == PLS_ON
            |=> state_q == PLS_LATCH ##1 !o_conv_en;
    endproperty
    a_latch_off: assert property (p_latch_off) else $error("no latch off");

    property p_hiccup;
        $changed(state_q) && state_q == PLS_HICCUP |-> tmr_q == TW'(HICCUP_CYC) && retry_q;
    endproperty
    a_hiccup: assert property (p_hiccup) else $error("hiccup wait wrong");

    property p_warn;
        warn_hit |=> o_temp_warning_flag && !o_smbalert_n;
    endproperty
    a_warn: assert property (p_warn) else $error("warning not flagged");

    property p_readback;
        i_cmd_valid && i_cmd_write && i_cmd_code == `PLS_CMD_WARN_THR &&
            i_cmd_wdata[15:6] == `PLS_WARN_FIXED |=> warn_mant_q == $past(i_cmd_wdata[5:0]);
    endproperty
    a_readback: assert property (p_readback) else $error("mantissa not stored");

    property p_ro_nack;
        i_cmd_valid && i_cmd_write && i_cmd_code == `PLS_CMD_TURN_ON_DLY &&
            i_cmd_wdata[15:3] != `PLS_TURN_ON_FIXED
            |=> o_cmd_nack && o_cmd_done && o_ivd_flag && o_cml_flag &&
                dly_mant_q == $past(dly_mant_q);
    endproperty
    a_ro_nack: assert property (p_ro_nack) else $error("read-only write taken");

    property p_vin_latch;
        running && vin_ov |=> state_q == PLS_LATCH && o_input_overvoltage_flag && !o_smbalert_n;
    endproperty
    a_vin_latch: assert property (p_vin_latch) else $error("overvoltage not latched");

    property p_min_delay;
        $changed(state_q) && state_q == PLS_DELAY && dly_mant_q == 3'h0
            |-> tmr_q == TW'(`PLS_MIN_DLY_CYC);
    endproperty
    a_min_delay: assert property (p_min_delay) else $error("minimum delay wrong");

    property p_vin_hold;
        state_q == PLS_LATCH && i_enable |=> state_q == PLS_LATCH;
    endproperty
    a_vin_hold: assert property (p_vin_hold) else $error("latch released early");

    c_hiccup:  cover property (state_q == PLS_HICCUP ##1 state_q == PLS_DELAY);
    c_latch:   cover property (state_q == PLS_ON ##1 state_q == PLS_LATCH);
    c_warn:    cover property ($rose(o_temp_warning_flag));
    c_nack:    cover property (o_cmd_nack && o_ivd_flag);

endmodule : pls_protect_regs
`default_nettype wire

// ==== pls_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// host side of the command port
// ----------------------------------------------------------------
module pls_host_model (
    input  wire logic        i_ref_clk,
    input  wire logic        i_cmd_done,
    input  wire logic        i_cmd_nack,
    input  wire logic [15:0] i_cmd_rdata,
    output logic             o_cmd_valid,
    output logic             o_cmd_write,
    output logic [7:0]       o_cmd_code,
    output logic [15:0]      o_cmd_wdata
);
    initial begin
        o_cmd_valid = 1'b0;
        o_cmd_write = 1'b0;
        o_cmd_code  = 8'h00;
        o_cmd_wdata = 16'h0000;
    end

    // strobe is one cycle, word held until the answer; released lines invert
    task automatic xfer(input int gap, input logic wr, input logic [7:0] code,
                        input logic [15:0] wd, output logic nack,
                        output logic [15:0] rd, output logic ok);
        int n;
        ok = 1'b0;
        nack = 1'b0;
        rd = 16'h0000;
        repeat (gap) @(negedge i_ref_clk);
        @(negedge i_ref_clk);
        o_cmd_valid = 1'b1;
        o_cmd_write = wr;
        o_cmd_code  = code;
        o_cmd_wdata = wd;
        // answer stands only in the cycle after the strobe edge
        for (n = 0; n < 4 && !ok; n++) begin
            @(negedge i_ref_clk);
            o_cmd_valid = 1'b0;
            if (i_cmd_done === 1'b1) begin
                ok = 1'b1;
                nack = i_cmd_nack;
                rd = i_cmd_rdata;
            end
        end
        o_cmd_write = ~wr;
        o_cmd_code  = ~code;
        o_cmd_wdata = ~wd;
    endtask : xfer
endmodule : pls_host_model
`default_nettype wire

// ==== tb_pls_protect_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp); \
        end \
    end
// ----------------------------------------------------------------
// bench
// ----------------------------------------------------------------
module tb_pls_protect_regs;
    logic        i_ref_clk, rst, valid, write, clear, en, otf, done, nack;
    logic        conv, ramp, wflag, fflag, vflag, cml, ivd, alert_n;
    logic [7:0]  code, temp;
    logic [15:0] wdata, vmv, rdata;
    logic [2:0]  rsel;
    logic        retry;
    logic [5:0]  warn_m, rise_m;
    logic [3:0]  vin_m;
    logic [2:0]  dly_m;
    int          num_errors, comparisons;
    logic [7:0]  codes [6] = '{8'h50, 8'h51, 8'h55, 8'h60, 8'h61, 8'h7A};

    pls_protect_regs #(.STEP_CYC(20), .HICCUP_CYC(50)) dut (
        .i_ref_clk(i_ref_clk), .i_rst(rst), .i_cmd_valid(valid), .i_cmd_write(write),
        .i_cmd_code(code), .i_cmd_wdata(wdata), .i_clear_faults(clear), .i_enable(en),
        .i_ot_fault(otf), .i_die_temp_c(temp), .i_power_input_voltage_mv(vmv),
        .o_cmd_done(done), .o_cmd_nack(nack), .o_cmd_rdata(rdata), .o_conv_en(conv),
        .o_dac_ramp(ramp), .o_rise_sel(rsel), .o_temp_warning_flag(wflag),
        .o_temp_fault_flag(fflag), .o_input_overvoltage_flag(vflag), .o_cml_flag(cml),
        .o_ivd_flag(ivd), .o_smbalert_n(alert_n));
    pls_host_model host (
        .i_ref_clk(i_ref_clk), .i_cmd_done(done), .i_cmd_nack(nack), .i_cmd_rdata(rdata),
        .o_cmd_valid(valid), .o_cmd_write(write), .o_cmd_code(code), .o_cmd_wdata(wdata));

    always #12.5 i_ref_clk = ~i_ref_clk;

    function automatic logic [15:0] exp_rd(input logic [7:0] c);
        case (c)
            8'h50: exp_rd = {8'h00, 2'b10, {6{retry}}};
            8'h51: exp_rd = {10'h040, warn_m};
            8'h55: exp_rd = {12'h080, vin_m};
            8'h60: exp_rd = {13'h1F00, dly_m};
            default: exp_rd = {10'h3E0, rise_m};
        endcase
    endfunction : exp_rd

    function automatic logic ok_wr(input logic [7:0] c, input logic [15:0] w);
        case (c)
            8'h50: ok_wr = w[15:6] == 10'h002 && (w[5:0] == 6'h00 || w[5:0] == 6'h3F);
            8'h51: ok_wr = w[15:6] == 10'h040;
            8'h55: ok_wr = w[15:4] == 12'h080;
            8'h60: ok_wr = w[15:3] == 13'h1F00;
            8'h61: ok_wr = w[15:6] == 10'h3E0;
            default: ok_wr = 1'b0;
        endcase
    endfunction : ok_wr

    // legal-looking word; a quarter get one fixed bit flipped
    function automatic logic [15:0] mk(input logic [7:0] c, input logic [31:0] r);
        case (c)
            8'h50: mk = {10'h002, r[6] ? {6{r[0]}} : r[5:0]};
            8'h51: mk = {10'h040, r[5:0]};
            8'h55: mk = {12'h080, r[3:0]};
            8'h60: mk = {13'h1F00, r[2:0]};
            default: mk = {10'h3E0, r[5:0]};
        endcase
        if (r[9:8] == 2'b00) mk ^= 16'h1000 << r[11:10];
    endfunction : mk

    task automatic complete_run();
        $display("num_errors=%0d comparisons=%0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    task automatic ran_out();
        num_errors++;
        $display("[FAIL] t=%0t wait ran out", $time);
        complete_run();
    endtask : ran_out

    task automatic clr();
        @(negedge i_ref_clk);
        clear = 1'b1;
        @(negedge i_ref_clk);
        clear = 1'b0;
    endtask : clr

    task automatic wr(input logic [7:0] c, input logic [15:0] w);
        logic nk, ok, good;
        logic [15:0] rd;
        good = ok_wr(c, w);
        host.xfer($urandom_range(2, 0), 1'b1, c, w, nk, rd, ok);
        if (ok !== 1'b1) ran_out();
        `CHK(nk, ~good)
        `CHK(cml, ~good)
        `CHK(ivd, ~good)
        `CHK(alert_n, good)
        if (good) begin
            case (c)
                8'h50: retry = w[5];
                8'h51: warn_m = w[5:0];
                8'h55: vin_m = w[3:0];
                8'h60: dly_m = w[2:0];
                default: rise_m = w[5:0];
            endcase
        end
        clr();
    endtask : wr

    task automatic rd_chk(input logic [7:0] c);
        logic nk, ok;
        logic [15:0] rd;
        host.xfer(0, 1'b0, c, 16'h0000, nk, rd, ok);
        if (ok !== 1'b1) ran_out();
        `CHK(nk, 1'b0)
        `CHK(rd, exp_rd(c))
    endtask : rd_chk

    task automatic wait_for(input logic sel, input logic val, input int lim, output int n);
        for (n = 0; n < lim; n++) begin
            @(negedge i_ref_clk);
            if ((sel ? ramp : conv) === val) return;
        end
        ran_out();
    endtask : wait_for

    initial begin
        int i, k, n, d;
        logic [7:0] c;
        i_ref_clk = 1'b0;
        {rst, clear, en, otf} = 4'hF << 3;
        temp = 8'h00;
        vmv = 16'h2EE0;
        {retry, warn_m, vin_m, dly_m, rise_m} = {1'b0, 6'h22, 4'h9, 3'h0, 6'h00};
        num_errors = 0;
        comparisons = 0;
        void'($urandom(32'h1f17));
        repeat (2) @(negedge i_ref_clk);
        rst = 1'b0;
        `CHK(alert_n, 1'b1)
        for (i = 0; i < 5; i++) rd_chk(codes[i]);
        for (i = 0; i < 60; i++) begin
            c = codes[$urandom_range(5, 0)];
            wr(c, mk(c, $urandom));
            if (c != 8'h7A) rd_chk(c);
        end
        wr(8'h50, 16'h0090);
        wr(8'h50, 16'h00BF);
        rd_chk(8'h50);
        wr(8'h50, 16'h0080);
        for (k = 0; k < 6; k++) begin
            wr(8'h61, {10'h3E0, 6'((2 << k) - 1)});
            `CHK(rsel, 3'(k))
        end
        // warning bins: one degree under stays quiet, at the bin it trips
        for (k = 0; k < 5; k++) begin
            wr(8'h51, {10'h040, 6'(k == 0 ? 27 : k == 4 ? 40 : 28 + k)});
            d = k == 0 ? 110 : 110 + 5 * k;
            temp = 8'(d - 1);
            repeat (2) @(negedge i_ref_clk);
            `CHK(wflag, 1'b0)
            temp = 8'(d);
            repeat (2) @(negedge i_ref_clk);
            `CHK(wflag, 1'b1)
            `CHK(alert_n, 1'b0)
            temp = 8'h00;
            clr();
        end
        for (k = 0; k < 2; k++) begin
            wr(8'h55, {12'h080, 4'(9 - k)});
            vmv = k ? 16'h4074 : 16'h4844;
            repeat (2) @(negedge i_ref_clk);
            `CHK(vflag, 1'b0)
            vmv = vmv + 16'h0001;
            repeat (2) @(negedge i_ref_clk);
            `CHK(vflag, 1'b1)
            `CHK(alert_n, 1'b0)
            vmv = 16'h2EE0;
            clr();
        end
        for (k = 0; k < 5; k++) begin
            wr(8'h60, {13'h1F00, 3'(k == 4 ? 7 : k)});
            wr(8'h61, {10'h3E0, 6'(k == 0 ? 0 : 1 << k)});
            d = k == 0 ? 2000 : k == 1 ? 20 : k == 2 ? 40 : 80;
            en = 1'b1;
            wait_for(1'b0, 1'b1, 2100, n);
            `CHK(n >= d && n <= d + 4, 1'b1)
            wait_for(1'b1, 1'b0, 700, n);
            `CHK(n >= (20 << k) - 2 && n <= (20 << k) + 2, 1'b1)
            `CHK(conv, 1'b1)
            en = 1'b0;
            wait_for(1'b0, 1'b0, 5, n);
        end
        wr(8'h60, 16'hF801);
        wr(8'h61, 16'hF800);
        for (k = 0; k < 3; k++) begin
            en = 1'b1;
            wait_for(1'b0, 1'b1, 200, n);
            wait_for(1'b1, 1'b0, 100, n);
            if (k == 2) vmv = 16'h4E20;
            else otf = 1'b1;
            wait_for(1'b0, 1'b0, 4, n);
            `CHK(k == 2 ? vflag : fflag, 1'b1)
            otf = 1'b0;
            vmv = 16'h2EE0;
            if (k == 1) begin
                wait_for(1'b0, 1'b1, 200, n);
                `CHK(n >= 60 && n <= 80, 1'b1)
            end else begin
                repeat (100) @(negedge i_ref_clk);
                `CHK(conv, 1'b0)
            end
            en = 1'b0;
            repeat (3) @(negedge i_ref_clk);
            clr();
            if (k == 0) wr(8'h50, 16'h00BF);
        end
        complete_run();
    end
endmodule : tb_pls_protect_regs
`default_nettype wire
